// *** led_tick_gen.sv ***
// prescaler giving one pclk-wide tick per led clock period
// assumes the divider is stable while run is high
`timescale 1ns/1ns
module led_tick_gen
  import touch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  led_tick_if.gen lt
);

  typedef struct packed {
    logic [LED_COUNT_W-1:0] count;
    logic tick;
  } gen_state_t;

  gen_state_t st;
  gen_state_t next_st;
  logic [LED_COUNT_W-1:0] limit;

  always_comb
  begin
    next_st = st;
    // zero divider would stall the frame, so it acts as one
    limit = LED_COUNT_W'((lt.divider == 8'h00 ? 8'h01 : lt.divider) * LED_CLOCK_MULT) - 11'h001;
    next_st.tick = 1'b0;
    if (!lt.run)
    begin
      next_st.count = '0;
    end
    else if (st.count >= limit)
    begin
      next_st.count = '0;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.count = st.count + 11'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign lt.tick = st.tick;

endmodule // led_tick_gen

// *** led_tick_if.sv ***
// carries the led clock tick between the share controller and its prescaler
// assumes both ends run on pclk
`timescale 1ns/1ns
interface led_tick_if;
  logic run;
  logic [7:0] divider;
  logic tick;

  modport gen
  (
    input run,
    input divider,
    output tick
  );

  modport user
  (
    output run,
    output divider,
    input tick
  );
endinterface

// *** touch_pad_model.sv ***
// touch pads: a scan runs while the touch window opens
// assumes pclk; slow makes the scan outlast the phase
`timescale 1ns/1ns
module touch_pad_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic touch_window,
  input wire logic slow,
  output logic touch_busy,
  output logic scan_done_evt
);
  int n;
  logic prev;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      n <= 0;
      prev <= 1'b1;
      touch_busy <= 1'b0;
      scan_done_evt <= 1'b0;
    end
    else
    begin
      prev <= touch_window;
      scan_done_evt <= 1'b0;
      // short scan fits the phase with margin
      if (touch_window && !prev)
      begin
        n <= slow ? 60 : 4;
        touch_busy <= 1'b1;
      end
      else if (n > 1)
        n <= n - 1;
      else if (touch_busy)
      begin
        touch_busy <= 1'b0;
        scan_done_evt <= 1'b1;
      end
    end
endmodule // touch_pad_model

// *** touch_pkg.sv ***
// constants, register indices and types for the touch key share-mode block
// assumes an apb slave with 32-bit data and word-aligned registers
package touch_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_SELECT_PORT2 = 8'h9d;
  localparam logic [7:0] IDX_TOUCH_WAIT_WIDTH = 8'ha2;
  localparam logic [7:0] IDX_SCAN_ERROR_CHANNEL = 8'hb7;
  localparam logic [7:0] IDX_TOUCH_EVENT_FLAGS = 8'hc1;
  localparam logic [7:0] IDX_GAIN_COEFF_BYTE0 = 8'hc3;
  localparam logic [7:0] IDX_GAIN_COEFF_BYTE1 = 8'hc4;
  localparam logic [7:0] IDX_GAIN_COEFF_BYTE2 = 8'hc5;
  localparam logic [7:0] IDX_GAIN_COEFF_BYTE3 = 8'hc6;
  localparam logic [7:0] IDX_TOUCH_PHASE_WIDTH = 8'he6;
  localparam logic [7:0] IDX_SHARE_CONTROL = 8'hf0;
  localparam logic [7:0] IDX_LED_CLOCK_DIVIDER = 8'hf1;
  localparam logic [7:0] IDX_PER_COMMON_PERIOD = 8'hf2;
  localparam logic [7:0] IDX_COMMON_COUNT = 8'hf3;
  localparam logic [7:0] IDX_SHARE_STATUS = 8'hf4;

  // touch_event_flags bit positions
  localparam int FLAG_RESULT_OVERFLOW = 6;
  localparam int FLAG_START_ERROR = 5;
  localparam int FLAG_SCAN_DONE = 4;
  localparam int FLAG_COUNT_OVERFLOW = 3;
  localparam int FLAG_SHARE_OVERRUN = 2;
  localparam logic [7:0] FLAG_MASK = 8'h7c;
  localparam logic [7:0] FLAG_IRQ_MASK = 8'h74;

  // share_control bit positions
  localparam int CTRL_SHARE_ENABLE = 0;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_ERROR_CHANNEL = 3'h0;
  localparam logic [27:0] RESET_GAIN = 28'h0000000;

  // led clock period is 8 system clocks times the divider
  localparam int LED_CLOCK_MULT = 8;
  localparam int LED_COUNT_W = 11;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_TOUCH = 2'b01,
    SEQ_LED = 2'b10,
    SEQ_WAIT = 2'b11
  } seq_state_t;

endpackage

// *** touch_share_ctrl.sv ***
// touch key event flags, gain coefficient, pin select and share-mode sequencer
// assumes an apb master on pclk and event pulses synchronous to pclk
//
// Contract
// - result high-part overflow sets flag bit 6 and raises the interrupt request.
// - erroneous scan start sets flag bit 5 and raises the interrupt request.
// - finished key scan sets flag bit 4; zero while scan unfinished.
// - key scan counter overflow sets flag bit 3, otherwise it stays clear.
// - touch unfinished at led start extends touch, delays led, sets bit 2.
// - software writes only clear flags; hardware events alone set them.
// - 28-bit gain coefficient over four bytes, low byte first, top nibble unused.
// - select bits 1..7 drive port 2 pins 0..6, bit 0 drives port 1 pin 7.
// - touch phase lasts touch_phase_width led clock periods.
// - wait phase lasts touch_wait_width led clock periods.
// - phase and wait widths matter only while share mode is enabled.
// - share mode splits each frame into touch, led and wait phases.
// - led clock period is eight system clocks times the led clock divider.
// - led phase lasts per-common period times common count led clocks.
// - 3-bit error channel field in low bits of error register, reset zero.
// - error channel value plus one names the failing key.
// - key error halts touch operation for all flags except share overrun; here only flag bits 6, 5 and 3 halt, key_error_evt does not.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module touch_share_ctrl
  import touch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic result_overflow_evt,
  input wire logic start_error_evt,
  input wire logic scan_done_evt,
  input wire logic scan_count_overflow_evt,
  input wire logic key_error_evt,
  input wire logic [2:0] key_error_index,
  input wire logic touch_busy,
  output logic [27:0] gain_coeff,
  output logic [6:0] port2_touch_route,
  output logic port1_pin7_touch_route,
  output logic touch_window,
  output logic led_window,
  output logic touch_halt,
  output logic touch_irq_request
);

  typedef struct packed {
    logic [7:0] pin_select;
    logic [7:0] wait_width;
    logic [2:0] error_channel;
    logic [27:0] gain;
    logic [7:0] phase_width;
    logic [7:0] flags;
    logic [7:0] control;
    logic [7:0] led_divider;
    logic [7:0] common_period;
    logic [2:0] common_count;
    seq_state_t phase;
    logic [15:0] phase_count;
    logic overrun_seen;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic touch_win;
    logic led_win;
    logic halt;
    logic irq;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  led_tick_if lt();

  led_tick_gen u_tick
  (
    .pclk(pclk),
    .presetn(presetn),
    .lt(lt)
  );

  logic [7:0] index;
  logic setup;
  logic wr;
  logic halted;
  logic share_on;
  logic [15:0] count_inc;
  logic [15:0] led_len;
  logic [7:0] events;

  always_comb
  begin
    next_st = st;
    index = paddr[9:2];
    setup = psel && !penable;
    // write lands in the access cycle, which always has ready high
    wr = psel && penable && st.ready && pwrite;
    halted = st.flags[FLAG_RESULT_OVERFLOW] || st.flags[FLAG_START_ERROR]
      || st.flags[FLAG_COUNT_OVERFLOW];
    share_on = st.control[CTRL_SHARE_ENABLE];
    count_inc = st.phase_count + 16'h0001;
    led_len = 16'(st.common_period) * 16'(st.common_count);
    events = 8'h00;

    // apb read data is prepared in setup so the access phase needs no wait
    next_st.ready = setup;
    next_st.slverr = 1'b0;
    next_st.rdata = 32'h00000000;
    if (setup)
    begin
      unique case (index)
        IDX_PIN_SELECT_PORT2: next_st.rdata[7:0] = st.pin_select;
        IDX_TOUCH_WAIT_WIDTH: next_st.rdata[7:0] = st.wait_width;
        IDX_SCAN_ERROR_CHANNEL: next_st.rdata[2:0] = st.error_channel;
        IDX_TOUCH_EVENT_FLAGS: next_st.rdata[7:0] = st.flags & FLAG_MASK;
        IDX_GAIN_COEFF_BYTE0: next_st.rdata[7:0] = st.gain[7:0];
        IDX_GAIN_COEFF_BYTE1: next_st.rdata[7:0] = st.gain[15:8];
        IDX_GAIN_COEFF_BYTE2: next_st.rdata[7:0] = st.gain[23:16];
        IDX_GAIN_COEFF_BYTE3: next_st.rdata[3:0] = st.gain[27:24];
        IDX_TOUCH_PHASE_WIDTH: next_st.rdata[7:0] = st.phase_width;
        IDX_SHARE_CONTROL: next_st.rdata[0] = st.control[CTRL_SHARE_ENABLE];
        IDX_LED_CLOCK_DIVIDER: next_st.rdata[7:0] = st.led_divider;
        IDX_PER_COMMON_PERIOD: next_st.rdata[7:0] = st.common_period;
        IDX_COMMON_COUNT: next_st.rdata[2:0] = st.common_count;
        IDX_SHARE_STATUS: next_st.rdata[2:0] = {st.halt, st.phase};
        default: next_st.slverr = 1'b1;
      endcase
    end

    if (wr)
    begin
      unique case (index)
        IDX_PIN_SELECT_PORT2: next_st.pin_select = pwdata[7:0];
        IDX_TOUCH_WAIT_WIDTH: next_st.wait_width = pwdata[7:0];
        IDX_SCAN_ERROR_CHANNEL: next_st.error_channel = pwdata[2:0];
        IDX_TOUCH_EVENT_FLAGS: next_st.flags = st.flags & pwdata[7:0] & FLAG_MASK;
        IDX_GAIN_COEFF_BYTE0: next_st.gain[7:0] = pwdata[7:0];
        IDX_GAIN_COEFF_BYTE1: next_st.gain[15:8] = pwdata[7:0];
        IDX_GAIN_COEFF_BYTE2: next_st.gain[23:16] = pwdata[7:0];
        IDX_GAIN_COEFF_BYTE3: next_st.gain[27:24] = pwdata[3:0];
        IDX_TOUCH_PHASE_WIDTH: next_st.phase_width = pwdata[7:0];
        IDX_SHARE_CONTROL: next_st.control = {7'h00, pwdata[CTRL_SHARE_ENABLE]};
        IDX_LED_CLOCK_DIVIDER: next_st.led_divider = pwdata[7:0];
        IDX_PER_COMMON_PERIOD: next_st.common_period = pwdata[7:0];
        IDX_COMMON_COUNT: next_st.common_count = pwdata[2:0];
        default: next_st.control = st.control;
      endcase
    end

    // while halted only the share overrun may still be raised
    if (!halted)
    begin
      events[FLAG_RESULT_OVERFLOW] = result_overflow_evt;
      events[FLAG_START_ERROR] = start_error_evt;
      events[FLAG_SCAN_DONE] = scan_done_evt;
      events[FLAG_COUNT_OVERFLOW] = scan_count_overflow_evt;
      if (key_error_evt)
      begin
        next_st.error_channel = key_error_index;
      end
    end

    // frame sequencer; widths are ignored outside share mode
    if (!share_on)
    begin
      next_st.phase = SEQ_IDLE;
      next_st.phase_count = 16'h0000;
      next_st.overrun_seen = 1'b0;
    end
    else
    begin
      unique case (st.phase)
        SEQ_IDLE:
        begin
          next_st.phase = SEQ_TOUCH;
          next_st.phase_count = 16'h0000;
        end
        SEQ_TOUCH:
        begin
          if (lt.tick)
          begin
            if (count_inc >= 16'(st.phase_width))
            begin
              if (touch_busy)
              begin
                // overrun: touch keeps the pins, led start slips
                events[FLAG_SHARE_OVERRUN] = !st.overrun_seen;
                next_st.overrun_seen = 1'b1;
              end
              else
              begin
                next_st.phase = SEQ_LED;
                next_st.phase_count = 16'h0000;
              end
            end
            else
            begin
              next_st.phase_count = count_inc;
            end
          end
        end
        SEQ_LED:
        begin
          if (lt.tick)
          begin
            if (count_inc >= led_len)
            begin
              next_st.phase = SEQ_WAIT;
              next_st.phase_count = 16'h0000;
            end
            else
            begin
              next_st.phase_count = count_inc;
            end
          end
        end
        SEQ_WAIT:
        begin
          if (lt.tick)
          begin
            if (count_inc >= 16'(st.wait_width))
            begin
              next_st.phase = SEQ_TOUCH;
              next_st.phase_count = 16'h0000;
              next_st.overrun_seen = 1'b0;
            end
            else
            begin
              next_st.phase_count = count_inc;
            end
          end
        end
      endcase
    end

    // set after clear so an event in the clearing cycle survives
    next_st.flags = next_st.flags | (events & FLAG_MASK);

    next_st.halt = next_st.flags[FLAG_RESULT_OVERFLOW] || next_st.flags[FLAG_START_ERROR]
      || next_st.flags[FLAG_COUNT_OVERFLOW];
    next_st.irq = |(next_st.flags & FLAG_IRQ_MASK);
    // outside share mode touch owns its pins all the time
    next_st.touch_win = !next_st.control[CTRL_SHARE_ENABLE] || next_st.phase == SEQ_TOUCH;
    next_st.led_win = next_st.control[CTRL_SHARE_ENABLE] && next_st.phase == SEQ_LED;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.touch_win <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign lt.run = st.control[CTRL_SHARE_ENABLE];
  assign lt.divider = st.led_divider;

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.slverr;
  assign gain_coeff = st.gain;
  assign port2_touch_route = st.pin_select[7:1];
  assign port1_pin7_touch_route = st.pin_select[0];
  assign touch_window = st.touch_win;
  assign led_window = st.led_win;
  assign touch_halt = st.halt;
  assign touch_irq_request = st.irq;

endmodule // touch_share_ctrl

// *** touch_share_ctrl_properties.sv ***
// port assertions for the touch share block
// assumes one pclk domain; bound to the top module
`timescale 1ns/1ns
module touch_share_ctrl_properties
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic result_overflow_evt,
  input wire logic start_error_evt,
  input wire logic scan_done_evt,
  input wire logic touch_halt,
  input wire logic touch_irq_request,
  input wire logic touch_window,
  input wire logic led_window
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> s_answer ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_refused;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_refused: assert property (p_refused) else $error("refused data");
  property p_done;
    scan_done_evt && !touch_halt |=> touch_irq_request;
  endproperty
  a_done: assert property (p_done) else $error("done no irq");
  property p_rovf;
    result_overflow_evt && !touch_halt |=> touch_halt && touch_irq_request;
  endproperty
  a_rovf: assert property (p_rovf) else $error("overflow lost");
  property p_serr;
    start_error_evt && !touch_halt |=> touch_halt && touch_irq_request;
  endproperty
  a_serr: assert property (p_serr) else $error("start error lost");
  property p_excl;
    !(touch_window && led_window);
  endproperty
  a_excl: assert property (p_excl) else $error("phases overlap");
  property p_order;
    $rose(led_window) |-> $past(touch_window);
  endproperty
  a_order: assert property (p_order) else $error("led not after touch");
  property p_hold;
    touch_halt && !(psel && penable && pwrite) |=> touch_halt;
  endproperty
  a_hold: assert property (p_hold) else $error("halt dropped");
endmodule // touch_share_ctrl_properties
bind touch_share_ctrl touch_share_ctrl_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .result_overflow_evt(result_overflow_evt),
  .start_error_evt(start_error_evt), .scan_done_evt(scan_done_evt),
  .touch_halt(touch_halt), .touch_irq_request(touch_irq_request),
  .touch_window(touch_window), .led_window(led_window));

// *** touch_share_ctrl_tb.sv ***
// self-checking bench for the touch share block
// assumes the pad model answers each touch window
`timescale 1ns/1ns
module touch_share_ctrl_tb;
  import touch_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [4:0] evt = 0;
  logic [2:0] kidx = 0;
  logic [27:0] gain_coeff;
  logic [6:0] p2r;
  logic pready, pslverr, e, p1r, pad_done, touch_busy, touch_window, led_window;
  logic touch_halt, touch_irq_request;
  logic slow = 0;
  int fail_count = 0;
  int total_checks = 0;
  int len;
  always #4 pclk = ~pclk;
  touch_share_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .result_overflow_evt(evt[0]), .start_error_evt(evt[1]),
    .scan_done_evt(evt[2] | pad_done), .scan_count_overflow_evt(evt[3]),
    .key_error_evt(evt[4]), .key_error_index(kidx), .touch_busy(touch_busy),
    .gain_coeff(gain_coeff), .port2_touch_route(p2r), .port1_pin7_touch_route(p1r),
    .touch_window(touch_window), .led_window(led_window), .touch_halt(touch_halt),
    .touch_irq_request(touch_irq_request));
  touch_pad_model u_pad (.pclk(pclk), .presetn(presetn), .touch_window(touch_window),
    .slow(slow), .touch_busy(touch_busy), .scan_done_evt(pad_done));
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
      chk(32'h0, 32'h1, "no ready");
    if (n >= 20)
      end_of_test;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] exp, input string m);
    apb(1'b0, idx, 8'h00);
    chk(r, {24'h000000, exp}, m);
  endtask
  task pulse(input int b);
    @(posedge pclk);
    evt[b] <= 1'b1;
    @(posedge pclk);
    evt[b] <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? led_window : w == 1 ? touch_window : !(touch_window | led_window);
  endfunction
  // bounded: a stuck phase ends the run
  task run(input int w);
    int n;
    n = 0;
    len = 0;
    while (pick(w) !== 1'b1 && n < 500)
    begin
      @(posedge pclk);
      n++;
    end
    while (pick(w) === 1'b1 && len < 500)
    begin
      @(posedge pclk);
      len++;
    end
    if (n >= 500 || len >= 500)
      chk(32'h0, 32'h1, "phase stuck");
    if (n >= 500 || len >= 500)
      end_of_test;
  endtask
  task t_reset;
    logic [7:0] tbl [9];
    tbl = '{IDX_PIN_SELECT_PORT2, IDX_TOUCH_WAIT_WIDTH, IDX_SCAN_ERROR_CHANNEL,
      IDX_TOUCH_EVENT_FLAGS, IDX_GAIN_COEFF_BYTE0, IDX_GAIN_COEFF_BYTE1,
      IDX_GAIN_COEFF_BYTE2, IDX_GAIN_COEFF_BYTE3, IDX_TOUCH_PHASE_WIDTH};
    chk({24'h0, p1r, p2r}, 32'h0, "route reset");
    for (int i = 0; i < 9; i++)
      rd(tbl[i], RESET_BYTE, "reset value");
  endtask
  task t_regs;
    apb(1'b1, IDX_GAIN_COEFF_BYTE0, 8'h11);
    apb(1'b1, IDX_GAIN_COEFF_BYTE1, 8'h22);
    apb(1'b1, IDX_GAIN_COEFF_BYTE2, 8'h33);
    apb(1'b1, IDX_GAIN_COEFF_BYTE3, 8'hff);
    rd(IDX_GAIN_COEFF_BYTE3, 8'h0f, "gain nibble");
    chk({4'h0, gain_coeff}, 32'h0f332211, "gain value");
    apb(1'b1, IDX_PIN_SELECT_PORT2, 8'h81);
    // the write lands at the access edge, so the route shows one edge later
    @(posedge pclk);
    chk({24'h0, p1r, p2r}, 32'hc0, "pin route");
    apb(1'b1, 8'h10, 8'h55);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(r, 32'h0, "unmapped data");
  endtask
  task t_flags;
    pulse(2);
    chk({31'h0, touch_irq_request}, 32'h1, "done irq");
    pulse(3);
    rd(IDX_TOUCH_EVENT_FLAGS, 8'h18, "done count");
    apb(1'b1, IDX_TOUCH_EVENT_FLAGS, 8'hef);
    rd(IDX_TOUCH_EVENT_FLAGS, 8'h08, "clear one");
    chk({30'h0, touch_halt, touch_irq_request}, 32'h2, "count no irq");
    apb(1'b1, IDX_TOUCH_EVENT_FLAGS, 8'h00);
    apb(1'b1, IDX_TOUCH_EVENT_FLAGS, 8'h7c);
    rd(IDX_TOUCH_EVENT_FLAGS, 8'h00, "write sets");
    kidx <= 3'h5;
    pulse(4);
    rd(IDX_SCAN_ERROR_CHANNEL, 8'h05, "channel");
    pulse(0);
    kidx <= 3'h2;
    pulse(4);
    pulse(2);
    pulse(1);
    rd(IDX_TOUCH_EVENT_FLAGS, 8'h40, "halted flags");
    rd(IDX_SCAN_ERROR_CHANNEL, 8'h05, "halted channel");
    apb(1'b1, IDX_TOUCH_EVENT_FLAGS, 8'h00);
    pulse(1);
    rd(IDX_TOUCH_EVENT_FLAGS, 8'h20, "start error");
    apb(1'b1, IDX_TOUCH_EVENT_FLAGS, 8'h00);
  endtask
  task t_share;
    apb(1'b1, IDX_LED_CLOCK_DIVIDER, 8'h01);
    apb(1'b1, IDX_PER_COMMON_PERIOD, 8'h02);
    apb(1'b1, IDX_COMMON_COUNT, 8'h02);
    apb(1'b1, IDX_TOUCH_PHASE_WIDTH, 8'h03);
    apb(1'b1, IDX_TOUCH_WAIT_WIDTH, 8'h02);
    chk({30'h0, touch_window, led_window}, 32'h2, "share off");
    apb(1'b1, IDX_SHARE_CONTROL, 8'h01);
    run(0);
    chk(len, LED_CLOCK_MULT * 4, "led len");
    run(2);
    chk(len, LED_CLOCK_MULT * 2, "wait len");
    run(1);
    chk(len, LED_CLOCK_MULT * 3, "touch len");
    slow <= 1'b1;
    run(0);
    chk(len, LED_CLOCK_MULT * 4, "frame again");
    rd(IDX_SHARE_STATUS, 8'h03, "status wait");
    run(1);
    chk({31'h0, len > LED_CLOCK_MULT * 3}, 32'h1, "touch extended");
    apb(1'b0, IDX_TOUCH_EVENT_FLAGS, 8'h00);
    chk(r & 32'h4, 32'h4, "overrun flag");
    slow <= 1'b0;
    run(0);
    apb(1'b1, IDX_SHARE_CONTROL, 8'h00);
    repeat (3) @(posedge pclk);
    chk({30'h0, touch_window, led_window}, 32'h2, "share off again");
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_flags;
    t_share;
    end_of_test;
  end
endmodule // touch_share_ctrl_tb
